// *** design/pmc_cfg.svh ***
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ----------------------------------------------------------------
// Register indices (word address = index, byte address = 4 * index)
// ----------------------------------------------------------------
`define PMC_IDX_SLOT_STATUS_TWO   10'h07A
`define PMC_IDX_PM_CAPS           10'h0C0

// ----------------------------------------------------------------
// Byte lanes of the writable capability fields
// ----------------------------------------------------------------
`define PMC_LANE_NEXT_PTR         1
`define PMC_LANE_SPECIAL_INIT     2
`define PMC_LANE_WAKE_MASK        3

// ----------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------
`define PMC_CAP_ID_VAL            8'h01
`define PMC_SPEC_REV_VAL          3'h3
`define PMC_WAKE_CLK_VAL          1'h0
`define PMC_STANDBY_CUR_VAL       3'h0
`define PMC_LOW_PWR_SUP_VAL       1'h0
`define PMC_RSVD_BIT_VAL          1'h0
`define PMC_NEXT_PTR_RST          8'hD0
`define PMC_SPECIAL_INIT_RST      1'h0
`define PMC_WAKE_MASK_RST         5'h19
`define PMC_SLOT_STATUS_TWO_VAL   16'h0000

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define PMC_RESP_OKAY             2'h0
`define PMC_RESP_DECODE_ERR       2'h3

`endif

// *** design/pmc_pkg.sv ***
package pmc_pkg;

    // ------------------------------------------------------------
    // Capability word layout, most significant field first
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] wake_event_support_mask;
        logic       second_low_power_support;
        logic       first_low_power_support;
        logic [2:0] standby_current_need;
        logic       special_init_required;
        logic       rsvd_20;
        logic       wake_event_clock_flag;
        logic [2:0] pm_spec_revision;
        logic [7:0] next_capability_pointer;
        logic [7:0] capability_identifier;
    } pmc_caps_t;

    // Avalon-MM request as seen by the slave
    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } pmc_av_req_t;

    typedef enum logic [2:0] {
        PMC_D0,
        PMC_D1,
        PMC_D2,
        PMC_D3HOT,
        PMC_D3COLD
    } pmc_pwr_t;

    typedef enum logic {
        PMC_BUS_IDLE,
        PMC_BUS_DONE
    } pmc_bus_t;

endpackage : pmc_pkg

// *** design/pmc_power_mgmt_capability_regs.sv ***
`timescale 1ns/1ns
`include "pmc_cfg.svh"

// Notes on behaviour
// - Capability identifier reads constant one
// - Bits 15:8 report next capability pointer
// - Revision field reads constant three
// - Wake-event clock flag reads zero
// - Special-init flag resets to zero
// - Standby current field reads zero
// - Both low-power state support bits read zero
// - Wake support mask resets to 11001b
// - Mask rewrite changes advertisement, not behaviour
// - No wake forwarding in D3cold
// - Slot status two reads all zero
module pmc_power_mgmt_capability_regs
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // Avalon-MM slave
    input  wire logic [9:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic [1:0]             avs_response,
    output logic                   avs_waitrequest,
    // Port power state and wake events
    input  wire pmc_pkg::pmc_pwr_t pwr_state,
    input  wire logic              wake_req,
    output logic                   wake_fwd,
    // Advertised fields for the rest of the port
    output pmc_pkg::pmc_caps_t     caps_word
);
    import pmc_pkg::*;

    // ----------------------------------------------------------------
    // Request capture
    // ----------------------------------------------------------------
    pmc_av_req_t req;
    pmc_bus_t    bus_ff;
    pmc_bus_t    nxt_bus;
    logic        hit_caps;
    logic        hit_slot2;
    logic        accept;

    // One driver for the whole carrier, not one per member
    assign req = '{read:       avs_read,
                   write:      avs_write,
                   address:    avs_address,
                   byteenable: avs_byteenable,
                   writedata:  avs_writedata};

    assign hit_caps  = (req.address == `PMC_IDX_PM_CAPS);
    assign hit_slot2 = (req.address == `PMC_IDX_SLOT_STATUS_TWO);

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // One wait cycle gives read data a full cycle from a flip-flop
    always_comb
    begin
        nxt_bus = bus_ff;
        unique case (bus_ff)
            PMC_BUS_IDLE:
            begin
                if (req.read || req.write)
                    nxt_bus = PMC_BUS_DONE;
            end
            PMC_BUS_DONE:
            begin
                nxt_bus = PMC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            bus_ff <= PMC_BUS_IDLE;
        else
            bus_ff <= nxt_bus;
    end

    assign avs_waitrequest = (req.read || req.write) && (bus_ff == PMC_BUS_IDLE);
    assign accept          = (bus_ff == PMC_BUS_DONE) && (req.read || req.write);

    // ----------------------------------------------------------------
    // Writable advertised fields
    // ----------------------------------------------------------------
    logic [7:0] next_ptr_ff;
    logic       special_init_ff;
    logic [4:0] wake_mask_ff;
    logic       wr_caps;

    // Only these three fields take writes; all else drops, unmapped words with a decode error
    assign wr_caps = accept && req.write && hit_caps;

    always_ff @(posedge mclk)
    begin
        if (rst)
            next_ptr_ff <= `PMC_NEXT_PTR_RST;
        else if (wr_caps && req.byteenable[`PMC_LANE_NEXT_PTR])
            next_ptr_ff <= req.writedata[15:8];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            special_init_ff <= `PMC_SPECIAL_INIT_RST;
        else if (wr_caps && req.byteenable[`PMC_LANE_SPECIAL_INIT])
            special_init_ff <= req.writedata[21];
    end

    // Advertised only; the wake gate never reads this
    always_ff @(posedge mclk)
    begin
        if (rst)
            wake_mask_ff <= `PMC_WAKE_MASK_RST;
        else if (wr_caps && req.byteenable[`PMC_LANE_WAKE_MASK])
            wake_mask_ff <= req.writedata[31:27];
    end

    // ----------------------------------------------------------------
    // Capability word assembly
    // ----------------------------------------------------------------
    pmc_caps_t caps;

    always_comb
    begin
        caps.capability_identifier    = `PMC_CAP_ID_VAL;
        caps.next_capability_pointer  = next_ptr_ff;
        caps.pm_spec_revision         = `PMC_SPEC_REV_VAL;
        caps.wake_event_clock_flag    = `PMC_WAKE_CLK_VAL;
        caps.rsvd_20                  = `PMC_RSVD_BIT_VAL;
        caps.special_init_required    = special_init_ff;
        caps.standby_current_need     = `PMC_STANDBY_CUR_VAL;
        caps.first_low_power_support  = `PMC_LOW_PWR_SUP_VAL;
        caps.second_low_power_support = `PMC_LOW_PWR_SUP_VAL;
        caps.wake_event_support_mask  = wake_mask_ff;
    end

    assign caps_word = caps;

    // ----------------------------------------------------------------
    // Read data and answer
    // ----------------------------------------------------------------
    logic [31:0] rdata_ff;
    logic [1:0]  resp_ff;
    logic        load;

    // Loaded on the wait cycle, stands through the answering edge
    assign load = (bus_ff == PMC_BUS_IDLE) && (req.read || req.write);

    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata_ff <= 32'h0000_0000;
        else if (load)
        begin
            if (req.read && hit_caps)
                rdata_ff <= caps;
            else if (req.read && hit_slot2)
                rdata_ff <= {16'h0000, `PMC_SLOT_STATUS_TWO_VAL};
            else
                rdata_ff <= 32'h0000_0000;
        end
    end

    // Unmapped words answer with a decode error and zero data
    always_ff @(posedge mclk)
    begin
        if (rst)
            resp_ff <= `PMC_RESP_OKAY;
        else if (load)
            resp_ff <= (hit_caps || hit_slot2) ? `PMC_RESP_OKAY : `PMC_RESP_DECODE_ERR;
    end

    assign avs_readdata = rdata_ff;
    assign avs_response = resp_ff;

    // ----------------------------------------------------------------
    // Wake forwarding
    // ----------------------------------------------------------------
    pmc_wake_gate u_wake_gate
    (
        .mclk      (mclk),
        .rst       (rst),
        .pwr_state (pwr_state),
        .wake_req  (wake_req),
        .wake_fwd  (wake_fwd)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic rd_caps_done;
    logic rd_slot2_done;

    assign rd_caps_done  = accept && req.read && hit_caps;
    assign rd_slot2_done = accept && req.read && hit_slot2;

    a_answer_bound: assert property (@(posedge mclk) disable iff (rst)
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("no answer within one wait cycle");

    a_cap_id_const: assert property (@(posedge mclk) disable iff (rst)
        rd_caps_done |-> (avs_readdata[7:0] == `PMC_CAP_ID_VAL))
        else $error("capability identifier wrong");

    a_next_ptr_wr: assert property (@(posedge mclk) disable iff (rst)
        (wr_caps && req.byteenable[`PMC_LANE_NEXT_PTR])
        |=> (caps_word.next_capability_pointer == $past(avs_writedata[15:8])))
        else $error("next pointer not written");

    a_rev_const: assert property (@(posedge mclk) disable iff (rst)
        rd_caps_done |-> (avs_readdata[18:16] == `PMC_SPEC_REV_VAL))
        else $error("revision field wrong");

    a_clk_flag_zero: assert property (@(posedge mclk) disable iff (rst)
        rd_caps_done |-> !avs_readdata[19])
        else $error("wake clock flag set");

    a_special_rst: assert property (@(posedge mclk)
        rst |=> !caps_word.special_init_required)
        else $error("special init not reset");

    a_fixed_zeros: assert property (@(posedge mclk) disable iff (rst)
        rd_caps_done |-> (avs_readdata[24:22] == 3'h0) && !avs_readdata[20])
        else $error("standby current or reserved bit set");

    a_low_pwr_zero: assert property (@(posedge mclk) disable iff (rst)
        rd_caps_done |-> (avs_readdata[26:25] == 2'h0))
        else $error("low power support advertised");

    a_mask_rst: assert property (@(posedge mclk)
        rst |=> (caps_word.wake_event_support_mask == `PMC_WAKE_MASK_RST))
        else $error("wake mask reset value wrong");

    a_fixed_wake: assert property (@(posedge mclk) disable iff (rst)
        (wake_req && (pwr_state == PMC_D3HOT) && !wake_mask_ff[3]) |=> wake_fwd)
        else $error("wake behaviour followed advertised mask");

    a_no_cold_fwd: assert property (@(posedge mclk) disable iff (rst)
        (wake_req && (pwr_state == PMC_D3COLD)) |=> !wake_fwd)
        else $error("wake forwarded in D3cold");

    a_slot2_zero: assert property (@(posedge mclk) disable iff (rst)
        rd_slot2_done |-> (avs_readdata == 32'h0000_0000) && (avs_response == `PMC_RESP_OKAY))
        else $error("slot status two not zero");

    a_ro_ignored: assert property (@(posedge mclk) disable iff (rst)
        (accept && req.write && !hit_caps) |=> $stable(caps_word))
        else $error("write outside capability word changed it");

    a_decode_error: assert property (@(posedge mclk) disable iff (rst)
        (accept && !hit_caps && !hit_slot2)
        |-> (avs_response == `PMC_RESP_DECODE_ERR) && (avs_readdata == 32'h0000_0000))
        else $error("unmapped word not answered with decode error");

    a_write_data_zero: assert property (@(posedge mclk) disable iff (rst)
        (accept && req.write) |-> (avs_readdata == 32'h0000_0000))
        else $error("write answered with nonzero read data");

    a_rdata_stands: assert property (@(posedge mclk) disable iff (rst)
        !load |=> $stable(avs_readdata) && $stable(avs_response))
        else $error("read answer changed without a request");

    a_wait_once: assert property (@(posedge mclk) disable iff (rst)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");

    a_ptr_reset: assert property (@(posedge mclk)
        rst |=> (caps_word.next_capability_pointer == `PMC_NEXT_PTR_RST))
        else $error("next pointer reset value wrong");

    a_special_written: assert property (@(posedge mclk) disable iff (rst)
        (wr_caps && req.byteenable[`PMC_LANE_SPECIAL_INIT])
        |=> (caps_word.special_init_required == $past(avs_writedata[21])))
        else $error("special init flag not written");

    a_mask_written: assert property (@(posedge mclk) disable iff (rst)
        (wr_caps && req.byteenable[`PMC_LANE_WAKE_MASK])
        |=> (caps_word.wake_event_support_mask == $past(avs_writedata[31:27])))
        else $error("advertised wake mask not written");

    a_d0_forwards: assert property (@(posedge mclk) disable iff (rst)
        (wake_req && (pwr_state == PMC_D0)) |=> wake_fwd)
        else $error("wake not forwarded in D0");

    a_low_states_quiet: assert property (@(posedge mclk) disable iff (rst)
        (wake_req && ((pwr_state == PMC_D1) || (pwr_state == PMC_D2))) |=> !wake_fwd)
        else $error("wake forwarded in an unsupported state");

    c_read_caps: cover property (@(posedge mclk) disable iff (rst) rd_caps_done);
    c_write_mask: cover property (@(posedge mclk) disable iff (rst)
        wr_caps && req.byteenable[`PMC_LANE_WAKE_MASK]);
    c_wake_fwd: cover property (@(posedge mclk) disable iff (rst) wake_fwd);
    c_cold_req: cover property (@(posedge mclk) disable iff (rst)
        wake_req && (pwr_state == PMC_D3COLD));
    c_unmapped: cover property (@(posedge mclk) disable iff (rst)
        accept && !hit_caps && !hit_slot2);

endmodule : pmc_power_mgmt_capability_regs

// *** design/pmc_wake_gate.sv ***
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module pmc_wake_gate
(
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           rst,
    // Power state and wake events
    input  wire pmc_pkg::pmc_pwr_t pwr_state,
    input  wire logic           wake_req,
    output logic                wake_fwd
);
    import pmc_pkg::*;

    // ----------------------------------------------------------------
    // Fixed wake behaviour
    // ----------------------------------------------------------------
    // Behaviour follows the reset mask only, never the advertised one
    localparam logic [4:0] FIXED_MASK = `PMC_WAKE_MASK_RST;

    logic wake_fwd_ff;
    logic nxt_wake_fwd;
    logic state_ok;

    always_comb
    begin
        state_ok     = FIXED_MASK[pwr_state];
        // Forwarding stops in the cold state even though mask bit is set
        nxt_wake_fwd = wake_req && state_ok && (pwr_state != PMC_D3COLD);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            wake_fwd_ff <= 1'b0;
        else
            wake_fwd_ff <= nxt_wake_fwd;
    end

    assign wake_fwd = wake_fwd_ff;

    a_cold_blocks_fwd: assert property (@(posedge mclk) disable iff (rst)
        (pwr_state == PMC_D3COLD) |=> !wake_fwd)
        else $error("wake forwarded in D3cold");

endmodule : pmc_wake_gate

// *** sim/pmc_power_mgmt_capability_regs_tb.sv ***
`timescale 1ns/1ns
`include "pmc_cfg.svh"

module pmc_power_mgmt_capability_regs_tb;
    import pmc_pkg::*;

    localparam int TIMEOUT_CYC = 4000;

    logic               mclk;
    logic               rst;
    logic [9:0]         avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [3:0]         avs_byteenable;
    logic [31:0]        avs_writedata;
    logic [31:0]        avs_readdata;
    logic [1:0]         avs_response;
    logic               avs_waitrequest;
    pmc_pwr_t           pwr_state;
    logic               wake_req;
    logic               wake_fwd;
    pmc_caps_t          caps_word;
    int                 errors;
    int                 n_compared;
    int                 cyc;

    pmc_power_mgmt_capability_regs i_dut
    (
        .mclk            (mclk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_byteenable  (avs_byteenable),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_response    (avs_response),
        .avs_waitrequest (avs_waitrequest),
        .pwr_state       (pwr_state),
        .wake_req        (wake_req),
        .wake_fwd        (wake_fwd),
        .caps_word       (caps_word)
    );

    // ------------------------------------------------------------
    // Clock, timeout, common helpers
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == TIMEOUT_CYC)
        begin
            errors = errors + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic pmc_caps_t mk_caps(input logic [4:0] m, input logic [7:0] p,
                                          input logic si);
        pmc_caps_t c;
        c = '0;
        c.capability_identifier   = 8'h01;
        c.pm_spec_revision        = 3'h3;
        c.next_capability_pointer = p;
        c.special_init_required   = si;
        c.wake_event_support_mask = m;
        return c;
    endfunction : mk_caps

    // Request stands until waitrequest is sampled low at a rising edge;
    // only the bench timeout ends a hung wait
    task automatic bus_op(input logic rd, input logic [9:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        avs_read       <= rd;
        avs_write      <= ~rd;
        avs_address    <= a;
        avs_byteenable <= be;
        avs_writedata  <= d;
        do
        begin
            @(posedge mclk);
            n = n + 1;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        r = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        chk("wait edges", 32'(n), 32'h2);
        @(posedge mclk);
    endtask : bus_op

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        logic [31:0] q;
        logic [1:0]  r;
        bus_op(1'b1, a, 4'hF, 32'h0000_0000, q, r);
        chk("read data", q, exp);
        chk("response", 32'(r), 32'(rsp));
    endtask : rd_chk

    task automatic wr(input logic [9:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0]  r;
        logic [1:0]  exp_r;
        exp_r = (a == `PMC_IDX_PM_CAPS || a == `PMC_IDX_SLOT_STATUS_TWO) ? 2'h0 : 2'h3;
        bus_op(1'b0, a, be, d, q, r);
        chk("write response", 32'(r), 32'(exp_r));
        chk("write data", q, 32'h0000_0000);
    endtask : wr

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        pmc_caps_t c;
        c = mk_caps(5'h19, `PMC_NEXT_PTR_RST, 1'b0);
        rd_chk(`PMC_IDX_PM_CAPS, c, 2'h0);
        chk("caps word", caps_word, c);
        rd_chk(`PMC_IDX_SLOT_STATUS_TWO, 32'h0000_0000, 2'h0);
    endtask : t_reset_values

    task automatic t_fixed_fields();
        wr(`PMC_IDX_SLOT_STATUS_TWO, 4'hF, 32'hFFFF_FFFF);
        rd_chk(`PMC_IDX_SLOT_STATUS_TWO, 32'h0000_0000, 2'h0);
        wr(10'h3FF, 4'hF, 32'hFFFF_FFFF);
        rd_chk(10'h3FF, 32'h0000_0000, 2'h3);
        wr(`PMC_IDX_PM_CAPS, 4'hF, 32'hFFFF_FFFF);
        rd_chk(`PMC_IDX_PM_CAPS, mk_caps(5'h1F, 8'hFF, 1'b1), 2'h0);
        chk("caps word", caps_word, mk_caps(5'h1F, 8'hFF, 1'b1));
        wr(`PMC_IDX_PM_CAPS, 4'h1, 32'h0000_0000);
        wr(`PMC_IDX_PM_CAPS, 4'h2, 32'h0000_0000);
        rd_chk(`PMC_IDX_PM_CAPS, mk_caps(5'h1F, 8'h00, 1'b1), 2'h0);
        wr(`PMC_IDX_PM_CAPS, 4'hC, 32'h0000_0000);
        rd_chk(`PMC_IDX_PM_CAPS, mk_caps(5'h00, 8'h00, 1'b0), 2'h0);
    endtask : t_fixed_fields

    // Forwarding must follow the default mask, D3cold excepted, whatever is advertised
    task automatic t_wake(input logic [4:0] adv);
        logic exp;
        wr(`PMC_IDX_PM_CAPS, 4'h8, {adv, 27'h0});
        chk("advertised mask", 32'(caps_word.wake_event_support_mask), 32'(adv));
        for (int s = 0; s < 5; s++)
        begin
            exp = (s == 0) || (s == 3);
            pwr_state <= pmc_pwr_t'(s[2:0]);
            wake_req  <= 1'b1;
            @(posedge mclk);
            wake_req  <= 1'b0;
            @(negedge mclk);
            chk("wake forward", 32'(wake_fwd), 32'(exp));
            @(negedge mclk);
            chk("wake pulse end", 32'(wake_fwd), 32'h0);
            @(posedge mclk);
        end
    endtask : t_wake

    task automatic t_rereset();
        pmc_caps_t c;
        c = mk_caps(5'h19, `PMC_NEXT_PTR_RST, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("wake after reset", 32'(wake_fwd), 32'h0);
        rd_chk(`PMC_IDX_PM_CAPS, c, 2'h0);
    endtask : t_rereset

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        errors         = 0;
        n_compared     = 0;
        cyc            = 0;
        rst            = 1'b1;
        avs_address    = 10'h000;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata  = 32'h0000_0000;
        pwr_state      = PMC_D0;
        wake_req       = 1'b0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset_values();
        t_fixed_fields();
        t_wake(5'h19);
        t_wake(5'h06);
        t_wake(5'h10);
        t_rereset();
        test_done();
    end

endmodule : pmc_power_mgmt_capability_regs_tb
